// ===== include/fcq_link_if.sv
`timescale 1ns/100ps
interface fcq_link_if;
    import fcq_pkg::*;
    logic req_valid;
    logic req_ready;
    logic [HALF_W-1:0] req_half;
    logic rsp_valid;
    logic rsp_ready;
    logic [WORD_W-1:0] rsp_word;

    modport dev(input req_valid, input req_half, input rsp_ready,
                output req_ready, output rsp_valid, output rsp_word);
    modport prog(output req_valid, output req_half, output rsp_ready,
                 input req_ready, input rsp_valid, input rsp_word);
endinterface

// ===== include/fcq_pkg.sv
package fcq_pkg;

    // Link word geometry
    localparam int HALF_W = 16;
    localparam int WORD_W = 32;
    localparam int RSP_ECHO_LSB = 16;

    // Operation codes as carried in the first half of a command
    localparam logic [15:0] OP_SUM_QUERY = 16'h000C;
    localparam logic [15:0] OP_QUAD_WRITE = 16'h000D;
    localparam logic [15:0] OPERAND_UNUSED = 16'h0000;

    // Response codes in the low half of the first reply word
    localparam logic [15:0] RSP_PASS = 16'h0000;
    localparam logic [15:0] RSP_FAIL = 16'h0002;
    localparam logic [15:0] RSP_BAD_OP = 16'h0003;

    // Quad write geometry and alignment
    localparam int QUAD_WORDS = 4;
    localparam logic [1:0] QUAD_ALIGN_BITS = 2'h0;
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;

    // Command lengths in halves
    localparam logic [3:0] SUM_HALVES = 4'h6;
    localparam logic [3:0] QUAD_HALVES = 4'hC;

    // Checksum sources
    localparam int CFG_WORDS = 4;
    localparam int ID_IDX = 4;
    localparam logic [31:0] CFG_BYTES = 32'h0000_0010;
    localparam int CP_BIT = 28;

    // Default memory regions
    localparam logic [31:0] PROG_BASE_DEF = 32'h1D00_0000;
    localparam logic [31:0] PROG_SIZE_DEF = 32'h0008_0000;
    localparam logic [31:0] BOOT_BASE_DEF = 32'h1FC0_0000;
    localparam logic [31:0] BOOT_SIZE_DEF = 32'h0000_3000;

    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_HALF = 16'h0000;

    // Per-family masks: four configuration words, then the identifier
    localparam logic [31:0] MASK_FAM_A [5] = '{32'h110F_F00B, 32'h009F_F7A7, 32'h0007_0077,
                                              32'h0000_FFFF, 32'h000F_F000};
    localparam logic [31:0] MASK_FAM_B [5] = '{32'h110F_F00F, 32'h009F_F7A7, 32'h0007_8777,
                                              32'hC707_FFFF, 32'h000F_F000};

    typedef enum logic [3:0] {
        ST_OP = 4'h0, ST_OPND = 4'h1, ST_AH = 4'h2, ST_AL = 4'h3,
        ST_LH = 4'h4, ST_LL = 4'h5, ST_DH = 4'h6, ST_DL = 4'h7,
        ST_RD = 4'h8, ST_RDW = 4'h9, ST_WR = 4'hA, ST_RSP0 = 4'hB,
        ST_RSP1 = 4'hC, ST_FIN = 4'hD
    } fcq_dev_state_t;

    typedef enum logic [1:0] {
        PH_QUERY = 2'h0, PH_PROG = 2'h1, PH_BOOT = 2'h2
    } fcq_phase_t;

    typedef enum logic [1:0] {
        HS_IDLE = 2'h0, HS_SEND = 2'h1, HS_RECV = 2'h2
    } fcq_host_state_t;

    // Sum of the four unsigned bytes of a word
    function automatic logic [31:0] fcq_byte_sum(input logic [31:0] w);
        logic [31:0] s;
        s = RST_WORD;
        for (int k = 0; k < 4; k++) begin
            s = s + {24'h00_0000, w[8*k +: 8]};
        end
        return s;
    endfunction

    // Mask lookup by family and source index
    function automatic logic [31:0] fcq_mask(input logic fam, input int idx);
        return fam ? MASK_FAM_B[idx] : MASK_FAM_A[idx];
    endfunction

endpackage

// ===== logic/fcq_agent.sv
// Behaviour
// - Sum query opcode 0x0C, address high then low
// - 32-bit byte length follows, high then low
// - Add every byte in range, one word result
// - Opcode 0x0D programs four consecutive words
// - Programmer sends halves in fixed order
// - Programmer supplies address with low bits zero
// - Misaligned write fails and leaves flash untouched
// - Checksum adds bytes into wrapping 32-bit sum
// - Boot region sum excludes configuration words
// - Checksum is two's complement of total
// - Masks mark implemented bits with ones
// - Configuration words masked before byte summing
// - Identifier masked before byte summing
// - Mask table holds per-family constants
// - Code-protected device reports zero checksum
`timescale 1ns/100ps
module fcq_agent
    import fcq_pkg::*;
#(
    parameter int BUF_DEPTH = 2,
    parameter logic FAMILY = 1'b0,
    parameter logic [31:0] PROG_BASE = PROG_BASE_DEF,
    parameter logic [31:0] PROG_SIZE = PROG_SIZE_DEF,
    parameter logic [31:0] BOOT_BASE = BOOT_BASE_DEF,
    parameter logic [31:0] BOOT_SIZE = BOOT_SIZE_DEF
)(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    fcq_link_if.dev link,
    output logic mem_rd_req_out,
    output logic mem_wr_req_out,
    output logic [31:0] mem_addr_out,
    output logic [31:0] mem_wr_data_out,
    input wire logic mem_rd_ack_in,
    input wire logic [31:0] mem_rd_data_in,
    input wire logic mem_wr_ack_in,
    input wire logic [3:0][31:0] cfg_word_in,
    input wire logic [31:0] part_id_in,
    input wire logic cks_start_in,
    output logic cks_busy_out,
    output logic cks_done_out,
    output logic [31:0] cks_value_out
);

    localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int CW = $clog2(BUF_DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(BUF_DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(BUF_DEPTH);

    logic [15:0] buf_q [BUF_DEPTH];
    logic [15:0] buf_d [BUF_DEPTH];
    logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic push, pop, take, buf_valid;
    logic [15:0] buf_half;

    fcq_dev_state_t st_q, st_d;
    fcq_phase_t ph_q, ph_d;
    logic [15:0] op_q, op_d;
    logic [31:0] addr_q, addr_d, len_q, len_d, acc_q, acc_d;
    logic [3:0][31:0] data_q, data_d;
    logic [1:0] idx_q, idx_d;
    logic [31:0] rsp_q, rsp_d, cks_q, cks_d;
    logic rd_q, rd_d, wr_q, wr_d, done_q, done_d;
    logic protect;

    // Two-entry buffer on incoming halves
    assign buf_valid = (cnt_q != '0);
    assign buf_half = buf_q[rp_q];
    assign link.req_ready = (cnt_q != CNT_FULL);
    assign push = link.req_valid && link.req_ready;
    assign pop = buf_valid && take;

    always_comb begin
        buf_d = buf_q;
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (push) begin
            buf_d[wp_q] = link.req_half;
            wp_d = (wp_q == PTR_LAST) ? '0 : wp_q + PW'(1);
        end
        if (pop) begin
            rp_d = (rp_q == PTR_LAST) ? '0 : rp_q + PW'(1);
        end
        if (push && !pop) begin
            cnt_d = cnt_q + CW'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int k = 0; k < BUF_DEPTH; k++) begin
                buf_q[k] <= RST_HALF;
            end
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            buf_q <= buf_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // Port drive from state registers
    assign protect = (cfg_word_in[0][CP_BIT] == 1'b0);
    assign link.rsp_valid = (st_q == ST_RSP0) || (st_q == ST_RSP1);
    assign link.rsp_word = rsp_q;
    assign mem_rd_req_out = rd_q;
    assign mem_wr_req_out = wr_q;
    assign mem_addr_out = {addr_q[31:2], 2'h0};
    assign mem_wr_data_out = data_q[idx_q];
    assign cks_busy_out = (ph_q != PH_QUERY);
    assign cks_done_out = done_q;
    assign cks_value_out = cks_q;

    // Command parser, byte summer and writer
    always_comb begin
        logic [2:0] avail;
        logic [2:0] tk;
        logic [31:0] step;
        logic [31:0] total;
        avail = 3'h4 - {1'b0, addr_q[1:0]};
        tk = (len_q < {29'h0000_0000, avail}) ? len_q[2:0] : avail;
        step = RST_WORD;
        for (int k = 0; k < 4; k++) begin
            if (k >= int'(addr_q[1:0]) && k < int'(addr_q[1:0]) + int'(tk)) begin
                step = step + {24'h00_0000, mem_rd_data_in[8*k +: 8]}; // Unsigned bytes
            end
        end
        total = acc_q;
        for (int x = 0; x < CFG_WORDS; x++) begin
            total = total + fcq_byte_sum(cfg_word_in[x] & fcq_mask(FAMILY, x));
        end
        total = total + fcq_byte_sum(part_id_in & fcq_mask(FAMILY, ID_IDX));
        st_d = st_q;
        ph_d = ph_q;
        op_d = op_q;
        addr_d = addr_q;
        len_d = len_q;
        acc_d = acc_q;
        data_d = data_q;
        idx_d = idx_q;
        rsp_d = rsp_q;
        cks_d = cks_q;
        rd_d = rd_q;
        wr_d = wr_q;
        done_d = 1'b0;
        take = 1'b0;
        case (st_q)
            ST_OP: begin
                if (cks_start_in) begin
                    if (protect) begin
                        cks_d = RST_WORD; // Protected part reads zero
                        done_d = 1'b1;
                    end else begin
                        ph_d = PH_PROG; // Whole program region first
                        addr_d = PROG_BASE;
                        len_d = PROG_SIZE;
                        acc_d = RST_WORD;
                        st_d = ST_RD;
                    end
                end else if (buf_valid) begin
                    take = 1'b1;
                    op_d = buf_half;
                    st_d = ST_OPND;
                end
            end
            ST_OPND: begin
                take = buf_valid; // Operand ignored
                if (buf_valid) st_d = ST_AH;
            end
            ST_AH: begin
                take = buf_valid;
                if (buf_valid) begin
                    addr_d[31:16] = buf_half;
                    st_d = ST_AL;
                end
            end
            ST_AL: begin
                take = buf_valid;
                if (buf_valid) begin
                    addr_d[15:0] = buf_half;
                    idx_d = 2'h0;
                    if (op_q == OP_SUM_QUERY) begin
                        st_d = ST_LH;
                    end else if (op_q == OP_QUAD_WRITE) begin
                        st_d = ST_DH;
                    end else begin
                        rsp_d = {op_q, RSP_BAD_OP};
                        st_d = ST_RSP0;
                    end
                end
            end
            ST_LH: begin
                take = buf_valid;
                if (buf_valid) begin
                    len_d[31:16] = buf_half;
                    st_d = ST_LL;
                end
            end
            ST_LL: begin
                take = buf_valid;
                if (buf_valid) begin
                    len_d[15:0] = buf_half;
                    acc_d = RST_WORD;
                    ph_d = PH_QUERY;
                    st_d = ST_RD;
                end
            end
            ST_DH: begin
                take = buf_valid;
                if (buf_valid) begin
                    data_d[idx_q][31:16] = buf_half;
                    st_d = ST_DL;
                end
            end
            ST_DL: begin
                take = buf_valid;
                if (buf_valid) begin
                    data_d[idx_q][15:0] = buf_half;
                    if (idx_q != 2'h3) begin
                        idx_d = idx_q + 2'h1;
                        st_d = ST_DH;
                    end else if (addr_q[1:0] != QUAD_ALIGN_BITS) begin
                        rsp_d = {op_q, RSP_FAIL}; // No write issued
                        st_d = ST_RSP0;
                    end else begin
                        idx_d = 2'h0;
                        wr_d = 1'b1;
                        st_d = ST_WR;
                    end
                end
            end
            ST_RD: begin
                if (len_q == RST_WORD) begin
                    if (ph_q == PH_QUERY) begin
                        rsp_d = {op_q, RSP_PASS};
                        st_d = ST_RSP0;
                    end else if (ph_q == PH_PROG) begin
                        ph_d = PH_BOOT;
                        addr_d = BOOT_BASE;
                        len_d = BOOT_SIZE - CFG_BYTES; // Config words left out
                        st_d = ST_RD;
                    end else begin
                        st_d = ST_FIN;
                    end
                end else begin
                    rd_d = 1'b1;
                    st_d = ST_RDW;
                end
            end
            ST_RDW: begin
                if (mem_rd_ack_in) begin
                    rd_d = 1'b0;
                    acc_d = acc_q + step; // Wraps modulo 2^32
                    addr_d = addr_q + {29'h0000_0000, tk};
                    len_d = len_q - {29'h0000_0000, tk};
                    st_d = ST_RD;
                end
            end
            ST_WR: begin
                if (mem_wr_ack_in) begin
                    if (idx_q == 2'h3) begin
                        wr_d = 1'b0;
                        rsp_d = {op_q, RSP_PASS};
                        st_d = ST_RSP0;
                    end else begin
                        idx_d = idx_q + 2'h1;
                        addr_d = addr_q + WORD_BYTES; // Consecutive words
                    end
                end
            end
            ST_FIN: begin
                cks_d = RST_WORD - total;
                done_d = 1'b1;
                ph_d = PH_QUERY;
                st_d = ST_OP;
            end
            ST_RSP0: begin
                if (link.rsp_ready) begin
                    if (op_q == OP_SUM_QUERY && rsp_q[15:0] == RSP_PASS) begin
                        rsp_d = acc_q; // Sum word after head
                        st_d = ST_RSP1;
                    end else begin
                        st_d = ST_OP;
                    end
                end
            end
            ST_RSP1: begin
                if (link.rsp_ready) st_d = ST_OP;
            end
            default: st_d = ST_OP;
        endcase
    end

    // Registers of the parser
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q <= ST_OP;
            ph_q <= PH_QUERY;
            op_q <= RST_HALF;
            addr_q <= RST_WORD;
            len_q <= RST_WORD;
            acc_q <= RST_WORD;
            data_q <= '0;
            idx_q <= 2'h0;
            rsp_q <= RST_WORD;
            cks_q <= RST_WORD;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ph_q <= ph_d;
            op_q <= op_d;
            addr_q <= addr_d;
            len_q <= len_d;
            acc_q <= acc_d;
            data_q <= data_d;
            idx_q <= idx_d;
            rsp_q <= rsp_d;
            cks_q <= cks_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            done_q <= done_d;
        end
    end

endmodule

// ===== logic/fcq_prog.sv
`timescale 1ns/100ps
module fcq_prog
    import fcq_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    fcq_link_if.prog link,
    input wire logic cmd_valid_in,
    output logic cmd_ready_out,
    input wire logic cmd_quad_in,
    input wire logic [31:0] cmd_addr_in,
    input wire logic [31:0] cmd_len_in,
    input wire logic [3:0][31:0] cmd_data_in,
    output logic cmd_refused_out,
    output logic rsp_valid_out,
    output logic [31:0] rsp_head_out,
    output logic [31:0] rsp_sum_out
);

    fcq_host_state_t st_q, st_d;
    logic [11:0][15:0] sh_q, sh_d;
    logic [3:0] n_q, n_d, i_q, i_d;
    logic quad_q, quad_d, w_q, w_d;
    logic ref_q, ref_d, done_q, done_d;
    logic [31:0] head_q, head_d, sum_q, sum_d;

    // Handshakes toward the link and the user
    assign cmd_ready_out = (st_q == HS_IDLE);
    assign link.req_valid = (st_q == HS_SEND);
    assign link.req_half = sh_q[i_q];
    assign link.rsp_ready = (st_q == HS_RECV);
    assign cmd_refused_out = ref_q;
    assign rsp_valid_out = done_q;
    assign rsp_head_out = head_q;
    assign rsp_sum_out = sum_q;

    // Command serialiser and reply collector
    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        n_d = n_q;
        i_d = i_q;
        quad_d = quad_q;
        w_d = w_q;
        ref_d = 1'b0;
        done_d = 1'b0;
        head_d = head_q;
        sum_d = sum_q;
        case (st_q)
            HS_IDLE: begin
                if (cmd_valid_in) begin
                    if (cmd_quad_in && cmd_addr_in[1:0] != QUAD_ALIGN_BITS) begin
                        ref_d = 1'b1; // Misaligned write never leaves
                    end else begin
                        sh_d = '0;
                        sh_d[0] = cmd_quad_in ? OP_QUAD_WRITE : OP_SUM_QUERY;
                        sh_d[1] = OPERAND_UNUSED;
                        sh_d[2] = cmd_addr_in[31:16]; // High half first
                        sh_d[3] = cmd_addr_in[15:0];
                        if (cmd_quad_in) begin
                            for (int k = 0; k < QUAD_WORDS; k++) begin
                                sh_d[4+2*k] = cmd_data_in[k][31:16];
                                sh_d[5+2*k] = cmd_data_in[k][15:0];
                            end
                        end else begin
                            sh_d[4] = cmd_len_in[31:16];
                            sh_d[5] = cmd_len_in[15:0];
                        end
                        n_d = cmd_quad_in ? QUAD_HALVES : SUM_HALVES;
                        quad_d = cmd_quad_in;
                        i_d = 4'h0;
                        st_d = HS_SEND;
                    end
                end
            end
            HS_SEND: begin
                if (link.req_ready) begin
                    if (i_q == n_q - 4'h1) begin
                        w_d = 1'b0;
                        st_d = HS_RECV;
                    end else begin
                        i_d = i_q + 4'h1;
                    end
                end
            end
            HS_RECV: begin
                if (link.rsp_valid) begin
                    if (!w_q) begin
                        head_d = link.rsp_word;
                        sum_d = RST_WORD;
                        if (quad_q || link.rsp_word[15:0] != RSP_PASS) begin
                            done_d = 1'b1;
                            st_d = HS_IDLE;
                        end else begin
                            w_d = 1'b1; // Sum word follows the head
                        end
                    end else begin
                        sum_d = link.rsp_word;
                        done_d = 1'b1;
                        st_d = HS_IDLE;
                    end
                end
            end
            default: st_d = HS_IDLE;
        endcase
    end

    // Registers of the serialiser
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q <= HS_IDLE;
            sh_q <= '0;
            n_q <= 4'h0;
            i_q <= 4'h0;
            quad_q <= 1'b0;
            w_q <= 1'b0;
            ref_q <= 1'b0;
            done_q <= 1'b0;
            head_q <= RST_WORD;
            sum_q <= RST_WORD;
        end else begin
            st_q <= st_d;
            sh_q <= sh_d;
            n_q <= n_d;
            i_q <= i_d;
            quad_q <= quad_d;
            w_q <= w_d;
            ref_q <= ref_d;
            done_q <= done_d;
            head_q <= head_d;
            sum_q <= sum_d;
        end
    end

endmodule

// ===== test/fcq_assertions.sv
`timescale 1ns/100ps
module fcq_assertions
    import fcq_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [HALF_W-1:0] req_half,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [WORD_W-1:0] rsp_word
);
    logic [3:0] idx_q, idx_d;
    logic [15:0] op_q, op_d;
    logic [1:0] alo_q, alo_d;
    logic rw_q, rw_d, take;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    assign take = req_valid && req_ready;
    // Half index, opcode, align bits, reply word
    always_comb begin
        idx_d = idx_q;
        op_d = op_q;
        alo_d = alo_q;
        rw_d = rw_q;
        if (take) begin
            idx_d = (idx_q == ((op_q == OP_SUM_QUERY) ? SUM_HALVES : QUAD_HALVES) - 4'h1) ? 4'h0 : idx_q + 4'h1;
            if (idx_q == 4'h0) op_d = req_half;
            if (idx_q == 4'h3) alo_d = req_half[1:0];
        end
        if (rsp_valid && rsp_ready) rw_d = (op_q == OP_SUM_QUERY) && !rw_q;
    end
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            idx_q <= 4'h0;
            op_q <= RST_HALF;
            alo_q <= 2'h0;
            rw_q <= 1'b0;
        end else begin
            idx_q <= idx_d;
            op_q <= op_d;
            alo_q <= alo_d;
            rw_q <= rw_d;
        end
    end
    chk_half_held: assert property (req_valid && !req_ready |=> req_valid && $stable(req_half))
        else $error("half not held");
    chk_word_held: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_word))
        else $error("reply not held");
    chk_op_first: assert property (take && idx_q == 4'h0 |-> req_half == OP_SUM_QUERY || req_half == OP_QUAD_WRITE)
        else $error("unknown opcode");
    chk_operand_unused: assert property (take && idx_q == 4'h1 |-> req_half == OPERAND_UNUSED)
        else $error("operand not unused");
    chk_head_echo: assert property (rsp_valid && !rw_q |-> rsp_word[31:16] == op_q)
        else $error("opcode not echoed");
    chk_reply_after_cmd: assert property (rsp_valid |-> idx_q == 4'h0)
        else $error("early reply");
    chk_quad_code: assert property (rsp_valid && !rw_q && op_q == OP_QUAD_WRITE
        |-> rsp_word[15:0] == ((alo_q == QUAD_ALIGN_BITS) ? RSP_PASS : RSP_FAIL))
        else $error("bad quad code");
    chk_sum_pass: assert property (rsp_valid && !rw_q && op_q == OP_SUM_QUERY |-> rsp_word[15:0] == RSP_PASS)
        else $error("sum head not pass");
    chk_reply_bound: assert property (take && idx_q != 4'h0 && idx_d == 4'h0 |-> ##[1:600] rsp_valid)
        else $error("no reply");
endmodule

// ===== test/flash_checksum_and_quad_write_tb.sv
`timescale 1ns/100ps
module flash_checksum_and_quad_write_tb;
    import fcq_pkg::*;
    localparam logic [31:0] RSZ = 32'h0000_0020;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic cv = 1'b0, cq = 1'b0, rd_ack = 1'b0, wr_ack = 1'b0, cks = 1'b0, wr2 = 1'b0;
    logic cr, rf, rv, rd_req, wr_req, done, w2;
    logic [31:0] ca = '0, cl = '0, rdata = '0, pid = '0, head, sum, addr, wdata, cval, s, ad, r;
    logic [3:0][31:0] cd = '0, cfg = '0;
    logic [31:0] exp_q[$];
    int n_mismatch = 0, checks = 0;
    fcq_link_if l1();
    fcq_link_if l2();
    always #4 clk_in = ~clk_in;
    fcq_prog fcq_prog_inst(.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(l1.prog), .cmd_valid_in(cv),
        .cmd_ready_out(cr), .cmd_quad_in(cq), .cmd_addr_in(ca), .cmd_len_in(cl), .cmd_data_in(cd),
        .cmd_refused_out(rf), .rsp_valid_out(rv), .rsp_head_out(head), .rsp_sum_out(sum));
    fcq_agent #(.PROG_SIZE(RSZ), .BOOT_SIZE(RSZ)) fcq_agent_inst(.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .link(l1.dev), .mem_rd_req_out(rd_req), .mem_wr_req_out(wr_req), .mem_addr_out(addr),
        .mem_wr_data_out(wdata), .mem_rd_ack_in(rd_ack), .mem_rd_data_in(rdata), .mem_wr_ack_in(wr_ack),
        .cfg_word_in(cfg), .part_id_in(pid), .cks_start_in(cks), .cks_busy_out(), .cks_done_out(done),
        .cks_value_out(cval));
    // Agent for the misaligned write
    if (1'b1) begin : side2
        fcq_agent #(.PROG_SIZE(RSZ), .BOOT_SIZE(RSZ)) fcq_agent_inst(.clk_in(clk_in), .sys_rst_in(sys_rst_in),
            .link(l2.dev), .mem_rd_req_out(), .mem_wr_req_out(w2), .mem_addr_out(), .mem_wr_data_out(),
            .mem_rd_ack_in(rd_ack), .mem_rd_data_in(rdata), .mem_wr_ack_in(wr_ack), .cfg_word_in(cfg),
            .part_id_in(pid), .cks_start_in(1'b0), .cks_busy_out(), .cks_done_out(), .cks_value_out());
    end
    fcq_assertions fcq_assertions_inst(.clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_valid(l1.req_valid),
        .req_ready(l1.req_ready), .req_half(l1.req_half), .rsp_valid(l1.rsp_valid),
        .rsp_ready(l1.rsp_ready), .rsp_word(l1.rsp_word));
    function automatic logic [31:0] mw(input logic [31:0] a);
        return {a[15:0] ^ 16'hC3A5, a[11:4], a[7:0] ^ 8'h96};
    endfunction
    function automatic logic [31:0] bs(input logic [31:0] w);
        return 32'(w[7:0]) + 32'(w[15:8]) + 32'(w[23:16]) + 32'(w[31:24]);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic drain();
        while (exp_q.size() != 0) @(posedge clk_in);
        #1;
    endtask
    task automatic go();
        cv = 1'b1;
        do @(posedge clk_in); while (!cr);
        #1 cv = 1'b0;
        drain();
    endtask
    task automatic send2(input logic [15:0] h);
        l2.req_valid = 1'b1;
        l2.req_half = h;
        do @(posedge clk_in); while (!l2.req_ready);
        #1;
    endtask
    // Flash stand-in
    always @(posedge clk_in) begin
        #1;
        rd_ack = rd_req && !rd_ack && $urandom_range(1) == 1;
        rdata = rd_ack ? mw(addr) : ~rdata;
        wr_ack = wr_req && $urandom_range(1) == 1;
    end
    // Result watcher
    always @(posedge clk_in) begin
        if (w2) wr2 = 1'b1;
        if (wr_req && wr_ack) begin
            check(addr, exp_q.pop_front());
            check(wdata, exp_q.pop_front());
        end
        if (rf) check({31'h0, l1.req_valid}, exp_q.pop_front());
        if (rv) begin
            check(head, exp_q.pop_front());
            check(sum, exp_q.pop_front());
        end
        if (done) check(cval, exp_q.pop_front());
        if (l2.rsp_valid && l2.rsp_ready) begin
            check(l2.rsp_word, exp_q.pop_front());
            check({31'h0, wr2}, exp_q.pop_front());
        end
    end
    initial begin
        #400_000;
        n_mismatch++;
        stop_test();
    end
    // Test sequence
    initial begin
        l2.req_valid = 1'b0;
        l2.req_half = RST_HALF;
        l2.rsp_ready = 1'b1;
        r = $urandom(32'h0000_DC7E);
        repeat (2) @(posedge clk_in);
        #1 sys_rst_in = 1'b0;
        for (int i = 0; i < 6; i++) begin
            ad = PROG_BASE_DEF + 32'($urandom_range(60));
            cl = (i == 0) ? '0 : 32'($urandom_range(13));
            foreach (cd[k]) cd[k] = $urandom();
            s = '0;
            for (logic [31:0] b = ad; b != ad + cl; b++) begin
                r = mw({b[31:2], 2'b00});
                s += 32'(r[8*b[1:0] +: 8]);
            end
            exp_q.push_back({OP_SUM_QUERY, RSP_PASS});
            exp_q.push_back(s);
            cq = 1'b0;
            ca = ad;
            go();
            ca = {ad[31:2], 2'b00};
            for (int k = 0; k < 4; k++) begin
                exp_q.push_back(ca + 32'(4 * k));
                exp_q.push_back(cd[k]);
            end
            exp_q.push_back({OP_QUAD_WRITE, RSP_PASS});
            exp_q.push_back('0);
            cq = 1'b1;
            go();
            exp_q.push_back('0);
            ca = ad | 32'h0000_0001;
            go();
            exp_q.push_back({OP_QUAD_WRITE, RSP_FAIL});
            exp_q.push_back('0);
            send2(OP_QUAD_WRITE);
            send2(OPERAND_UNUSED);
            send2(ca[31:16]);
            send2(ca[15:0]);
            for (int k = 0; k < 4; k++) begin
                send2(cd[k][31:16]);
                send2(cd[k][15:0]);
            end
            l2.req_valid = 1'b0;
            l2.req_half = ~l2.req_half;
            drain();
            foreach (cfg[k]) cfg[k] = $urandom();
            cfg[0][CP_BIT] = (i != 5);
            pid = $urandom();
            s = bs(pid & MASK_FAM_A[ID_IDX]);
            for (int k = 0; 32'(4 * k) < RSZ; k++) s += bs(mw(PROG_BASE_DEF + 32'(4 * k)));
            for (int k = 0; 32'(4 * k) < RSZ - CFG_BYTES; k++) s += bs(mw(BOOT_BASE_DEF + 32'(4 * k)));
            for (int k = 0; k < CFG_WORDS; k++) s += bs(cfg[k] & MASK_FAM_A[k]);
            exp_q.push_back(cfg[0][CP_BIT] ? -s : '0);
            cks = 1'b1;
            @(posedge clk_in);
            #1 cks = 1'b0;
            drain();
        end
        stop_test();
    end
endmodule
